// ### common/pmwc_regs.svh
`ifndef PMWC_REGS_SVH
`define PMWC_REGS_SVH

// system_mode_register bit positions
`define PMWC_SYSTEM_MODE_REGISTER_FAST_SEL 0
`define PMWC_SYSTEM_MODE_REGISTER_IDLE_EN 1
`define PMWC_SYSTEM_MODE_REGISTER_FAST_RDY 2
`define PMWC_SYSTEM_MODE_REGISTER_SLOW_RDY 3
`define PMWC_SYSTEM_MODE_REGISTER_FAST_WAKE 4
`define PMWC_SYSTEM_MODE_REGISTER_DIV_LO 5
`define PMWC_SYSTEM_MODE_REGISTER_DIV_HI 7
`define PMWC_SYSTEM_MODE_REGISTER_RESET 8'h03
`define PMWC_SYSTEM_MODE_REGISTER_WR_MASK 8'hF3

// clock_divider_select codes
`define PMWC_DIV_SUB_A 3'h0
`define PMWC_DIV_SUB_B 3'h1

// oscillator settle counts, in oscillator ticks
`define PMWC_CNT_W 10
`define PMWC_FXT_SETTLE 10'h200
`define PMWC_FRC_SETTLE 10'h010
`define PMWC_SXT_SETTLE 10'h080
`define PMWC_SRC_SETTLE 10'h002
`define PMWC_SUB_WAKE 10'h002

`endif

// ### common/pmwc_pkg.sv
package pmwc_pkg;

	typedef enum logic [8:0] {
		PMWC_RUN_FAST  = 9'h001,
		PMWC_RUN_SLOW  = 9'h002,
		PMWC_SLEEP_ALL = 9'h004,
		PMWC_SLEEP_SUB = 9'h008,
		PMWC_IDLE_OFF  = 9'h010,
		PMWC_IDLE_ON   = 9'h020,
		PMWC_WAKE_FAST = 9'h040,
		PMWC_WAKE_SUB  = 9'h080,
		PMWC_WAKE_SLOW = 9'h100
	} pmwc_state_t;

	typedef struct packed {
		logic fast_is_crystal;
		logic slow_is_crystal;
		logic wdt_enable;
		logic lvd_enable;
	} pmwc_osc_cfg_t;

	typedef struct packed {
		logic cpu;
		logic sys_fast;
		logic sys_sub;
		logic time_base;
		logic wdt;
		logic fast_osc;
		logic slow_osc;
	} pmwc_clk_en_t;

endpackage

// ### logic/pmwc_stab_cnt.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmwc_regs.svh"

module pmwc_stab_cnt (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// oscillator
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic [`PMWC_CNT_W-1:0] i_target,
	// status
	output logic o_ready
);
	logic [`PMWC_CNT_W-1:0] count;
	wire logic reached = (count >= i_target);
	wire logic [`PMWC_CNT_W-1:0] next_count =
		!i_run ? '0 : (i_tick && !reached) ? count + 1'b1 : count;

	// stopped oscillator loses its settle history
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count <= '0;
			o_ready <= 1'b0;
		end else begin
			count <= next_count;
			o_ready <= i_run && (next_count >= i_target);
		end
	end
endmodule
`default_nettype wire

// ### logic/pmwc_fdiv.sv
`timescale 1ns/1ps
`default_nettype none

module pmwc_fdiv (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// fast oscillator
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic [2:0] i_shift,
	// divided ticks
	output logic o_sys_tick,
	output logic o_div16_tick,
	output logic o_div64_tick
);
	logic [5:0] phase;

	function automatic logic ones_below(input logic [5:0] v, input logic [2:0] k);
		logic [5:0] m;
		m = 6'(( 7'h01 << k) - 7'h01);
		return (v & m) == m;
	endfunction

	wire logic live = i_run && i_tick;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase <= 6'h00;
			o_sys_tick <= 1'b0;
			o_div16_tick <= 1'b0;
			o_div64_tick <= 1'b0;
		end else begin
			phase <= !i_run ? 6'h00 : live ? phase + 6'h01 : phase;
			o_sys_tick <= live && ones_below(phase, i_shift);
			o_div16_tick <= live && ones_below(phase, 3'h4);
			o_div64_tick <= live && ones_below(phase, 3'h6);
		end
	end
endmodule
`default_nettype wire

// ### logic/pmwc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmwc_regs.svh"

// Function
// - fast wake-up only leaving sleep_sub_on or idle_sys_off, where sub clock runs
// - waking from sleep_all_off ignores fast_wake_enable
// - crystal fast clock plus fast wake: run on sub clock until 512 ticks
// - internal RC fast: 15~16 ticks; slow RC: 1~2 ticks; fast wake ignored
// - watchdog and detector off with idle off means slow oscillators off, no fast wake from sleep_all_off
// - run modes by fast_clock_select and divider; halt chooses sleep or idle
// - selecting sub clock stops fast oscillator and its /16 and /64 ticks
// - fast_clock_select 0 with divider 000 or 001 gives low-speed run mode
// - low-speed switch waits for slow_osc_ready
// - fast select or divider 010..111 returns to high-speed run mode after fast_osc_ready
// - sleep_all_off only when idle off and watchdog and detector both off
// - sleep_all_off stops system, watchdog, time-base clocks; clears watchdog
// - sleep_sub_on keeps watchdog and detector on sub clock; watchdog cleared
// - idle_sys_off when idle_enable 1 and idle_clock_keep 0
// - idle_sys_off stops system clock, keeps time-base and sub clock
// - any halt entry sets power_down_flag and clears watchdog_timeout_flag unless a timeout comes in the same cycle
// - idle_sys_on when both idle bits set; all clocks but the CPU clock keep running
// - slow_osc_ready after 128 crystal ticks or 1~2 RC ticks
// - fast_wake_enable is bit 4 of system_mode_register, crystal only
module pmwc_top (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// oscillator ticks, one cycle each
	input wire logic i_fast_tick,
	input wire logic i_slow_tick,
	// configuration
	input wire pmwc_pkg::pmwc_osc_cfg_t i_osc_cfg,
	input wire logic i_idle_clock_keep,
	// system_mode_register access
	input wire logic i_system_mode_register_wr,
	input wire logic [7:0] i_system_mode_register_wdata,
	output logic [7:0] o_system_mode_register_rdata,
	// processor events
	input wire logic i_halt,
	input wire logic i_wake,
	input wire logic i_wdt_clear_instr,
	input wire logic i_wdt_timeout,
	// status
	output logic o_power_down_flag,
	output logic o_watchdog_timeout_flag,
	output logic o_wdt_clear,
	output pmwc_pkg::pmwc_state_t o_state,
	// clock enables
	output pmwc_pkg::pmwc_clk_en_t o_clk_en,
	output logic o_sys_tick,
	output logic o_fh16_tick,
	output logic o_fh64_tick
);

	//----------------------------------------
	// mode register
	//----------------------------------------
	logic [7:0] system_mode_register;
	pmwc_pkg::pmwc_state_t state;
	logic [1:0] sub_wake_cnt;
	logic fast_ready;
	logic slow_ready;

	wire logic fast_sel = system_mode_register[`PMWC_SYSTEM_MODE_REGISTER_FAST_SEL];
	wire logic idle_en = system_mode_register[`PMWC_SYSTEM_MODE_REGISTER_IDLE_EN];
	wire logic fast_wake_en = system_mode_register[`PMWC_SYSTEM_MODE_REGISTER_FAST_WAKE];
	wire logic [2:0] div_sel = system_mode_register[`PMWC_SYSTEM_MODE_REGISTER_DIV_HI:`PMWC_SYSTEM_MODE_REGISTER_DIV_LO];

	wire logic [7:0] next_system_mode_register =
		(i_system_mode_register_wdata & `PMWC_SYSTEM_MODE_REGISTER_WR_MASK) | (system_mode_register & ~`PMWC_SYSTEM_MODE_REGISTER_WR_MASK);

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			system_mode_register <= `PMWC_SYSTEM_MODE_REGISTER_RESET;
		end else if (i_system_mode_register_wr) begin
			system_mode_register <= next_system_mode_register;
		end
	end

	//----------------------------------------
	// clock source decode
	//----------------------------------------
	function automatic logic sel_is_sub(input logic fs, input logic [2:0] d);
		return !fs && (d == `PMWC_DIV_SUB_A || d == `PMWC_DIV_SUB_B);
	endfunction

	// divider shift: f_H/2^k, 0 when fast_clock_select is set
	function automatic logic [2:0] div_shift(input logic fs, input logic [2:0] d);
		return fs ? 3'h0 : 3'(4'h8 - {1'b0, d});
	endfunction

	wire logic want_sub = sel_is_sub(fast_sel, div_sel);
	wire logic want_fast = !want_sub;
	wire logic [2:0] shift = div_shift(fast_sel, div_sel);

	wire logic in_run =
		(state == pmwc_pkg::PMWC_RUN_FAST) || (state == pmwc_pkg::PMWC_RUN_SLOW);
	wire logic in_low =
		(state == pmwc_pkg::PMWC_SLEEP_ALL) || (state == pmwc_pkg::PMWC_SLEEP_SUB) ||
		(state == pmwc_pkg::PMWC_IDLE_OFF) || (state == pmwc_pkg::PMWC_IDLE_ON);
	wire logic sub_alive = (state == pmwc_pkg::PMWC_SLEEP_SUB) ||
		(state == pmwc_pkg::PMWC_IDLE_OFF);
	wire logic wdt_or_lvd = i_osc_cfg.wdt_enable || i_osc_cfg.lvd_enable;

	//----------------------------------------
	// oscillator run control
	//----------------------------------------
	// idle_sys_on keeps whatever system oscillator was running
	wire logic fast_run =
		(in_run && want_fast) ||
		(state == pmwc_pkg::PMWC_IDLE_ON && want_fast) ||
		(state == pmwc_pkg::PMWC_WAKE_FAST) ||
		(state == pmwc_pkg::PMWC_WAKE_SUB) ||
		(state == pmwc_pkg::PMWC_RUN_SLOW && want_fast);

	// only sleep_all_off stops the sub clock
	wire logic slow_run = (state != pmwc_pkg::PMWC_SLEEP_ALL);

	wire logic [`PMWC_CNT_W-1:0] fast_target =
		i_osc_cfg.fast_is_crystal ? `PMWC_FXT_SETTLE : `PMWC_FRC_SETTLE;
	wire logic [`PMWC_CNT_W-1:0] slow_target =
		i_osc_cfg.slow_is_crystal ? `PMWC_SXT_SETTLE : `PMWC_SRC_SETTLE;

	pmwc_stab_cnt u_fast_stab (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_run(fast_run),
		.i_tick(i_fast_tick),
		.i_target(fast_target),
		.o_ready(fast_ready)
	);

	pmwc_stab_cnt u_slow_stab (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_run(slow_run),
		.i_tick(i_slow_tick),
		.i_target(slow_target),
		.o_ready(slow_ready)
	);

	pmwc_fdiv u_fdiv (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_run(fast_run),
		.i_tick(i_fast_tick),
		.i_shift(shift),
		.o_sys_tick(o_sys_tick),
		.o_div16_tick(o_fh16_tick),
		.o_div64_tick(o_fh64_tick)
	);

	//----------------------------------------
	// halt target
	//----------------------------------------
	function automatic pmwc_pkg::pmwc_state_t halt_target(
		input logic ie, input logic keep, input logic wl);
		if (!ie) begin
			return wl ? pmwc_pkg::PMWC_SLEEP_SUB : pmwc_pkg::PMWC_SLEEP_ALL;
		end else begin
			return keep ? pmwc_pkg::PMWC_IDLE_ON : pmwc_pkg::PMWC_IDLE_OFF;
		end
	endfunction

	wire pmwc_pkg::pmwc_state_t halt_next =
		halt_target(idle_en, i_idle_clock_keep, wdt_or_lvd);
	wire logic halt_take = in_run && i_halt;

	// fast wake needs a crystal and a live sub clock
	wire logic use_fast_wake = i_osc_cfg.fast_is_crystal && fast_wake_en &&
		sub_alive;

	wire pmwc_pkg::pmwc_state_t wake_next =
		want_sub ? pmwc_pkg::PMWC_WAKE_SLOW :
		use_fast_wake ? pmwc_pkg::PMWC_WAKE_SUB : pmwc_pkg::PMWC_WAKE_FAST;

	wire logic sub_wake_done = (10'(sub_wake_cnt) >= `PMWC_SUB_WAKE);

	//----------------------------------------
	// mode sequencer
	//----------------------------------------
	pmwc_pkg::pmwc_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			pmwc_pkg::PMWC_RUN_FAST: begin
				if (i_halt) begin
					next_state = halt_next;
				end else if (want_sub && slow_ready) begin
					next_state = pmwc_pkg::PMWC_RUN_SLOW;
				end
			end
			pmwc_pkg::PMWC_RUN_SLOW: begin
				if (i_halt) begin
					next_state = halt_next;
				end else if (want_fast && fast_ready) begin
					next_state = pmwc_pkg::PMWC_RUN_FAST;
				end
			end
			pmwc_pkg::PMWC_SLEEP_ALL,
			pmwc_pkg::PMWC_SLEEP_SUB,
			pmwc_pkg::PMWC_IDLE_OFF,
			pmwc_pkg::PMWC_IDLE_ON: begin
				if (i_wake) begin
					next_state = wake_next;
				end
			end
			pmwc_pkg::PMWC_WAKE_FAST: begin
				if (fast_ready) begin
					next_state = pmwc_pkg::PMWC_RUN_FAST;
				end
			end
			pmwc_pkg::PMWC_WAKE_SUB: begin
				if (fast_ready) begin
					next_state = pmwc_pkg::PMWC_RUN_FAST;
				end
			end
			pmwc_pkg::PMWC_WAKE_SLOW: begin
				if (slow_ready) begin
					next_state = pmwc_pkg::PMWC_RUN_SLOW;
				end
			end
			default: begin
				next_state = pmwc_pkg::PMWC_RUN_FAST;
			end
		endcase
	end

	// sub ticks seen in the fast-wake window: 1~2 sub periods to run
	wire logic [1:0] next_sub_wake_cnt =
		(state != pmwc_pkg::PMWC_WAKE_SUB) ? 2'h0 :
		(i_slow_tick && !sub_wake_done) ? sub_wake_cnt + 2'h1 : sub_wake_cnt;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= pmwc_pkg::PMWC_RUN_FAST;
			sub_wake_cnt <= 2'h0;
		end else begin
			state <= next_state;
			sub_wake_cnt <= next_sub_wake_cnt;
		end
	end

	//----------------------------------------
	// status flags
	//----------------------------------------
	// set beats clear: halt over clear instruction, timeout over halt
	wire logic next_pdf = halt_take || (o_power_down_flag && !i_wdt_clear_instr);
	wire logic next_to = i_wdt_timeout || (o_watchdog_timeout_flag && !halt_take);

	// watchdog cleared on every halt entry; stopped too in sleep_all_off
	wire logic next_wdt_clear = halt_take;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_power_down_flag <= 1'b0;
			o_watchdog_timeout_flag <= 1'b0;
			o_wdt_clear <= 1'b0;
		end else begin
			o_power_down_flag <= next_pdf;
			o_watchdog_timeout_flag <= next_to;
			o_wdt_clear <= next_wdt_clear;
		end
	end

	//----------------------------------------
	// clock enables
	//----------------------------------------
	wire logic ns_run = (next_state == pmwc_pkg::PMWC_RUN_FAST) ||
		(next_state == pmwc_pkg::PMWC_RUN_SLOW);
	wire logic ns_sub_cpu = (next_state == pmwc_pkg::PMWC_WAKE_SUB) &&
		(10'(next_sub_wake_cnt) >= `PMWC_SUB_WAKE);
	wire logic ns_slow_src = (next_state == pmwc_pkg::PMWC_RUN_SLOW) ||
		(next_state == pmwc_pkg::PMWC_IDLE_ON && want_sub) || ns_sub_cpu;
	wire logic ns_sys_on = ns_run || ns_sub_cpu ||
		(next_state == pmwc_pkg::PMWC_IDLE_ON);
	wire logic ns_tbc = ns_sys_on ||
		(next_state == pmwc_pkg::PMWC_IDLE_OFF);
	// sleep_sub_on keeps watchdog on sub; sleep_all_off stops it
	wire logic ns_wdt = i_osc_cfg.wdt_enable &&
		(next_state != pmwc_pkg::PMWC_SLEEP_ALL);

	pmwc_pkg::pmwc_clk_en_t next_clk_en;

	always_comb begin
		next_clk_en.cpu = ns_run || ns_sub_cpu;
		next_clk_en.sys_sub = ns_sys_on && ns_slow_src;
		next_clk_en.sys_fast = ns_sys_on && !ns_slow_src;
		next_clk_en.time_base = ns_tbc;
		next_clk_en.wdt = ns_wdt;
		next_clk_en.fast_osc = fast_run;
		// follows the state being entered, so deep sleep shows it off at once
		next_clk_en.slow_osc = (next_state != pmwc_pkg::PMWC_SLEEP_ALL);
	end

	wire logic [7:0] next_rdata = {div_sel, fast_wake_en, slow_ready, fast_ready,
		idle_en, fast_sel};

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_clk_en <= '0;
			o_state <= pmwc_pkg::PMWC_RUN_FAST;
			o_system_mode_register_rdata <= `PMWC_SYSTEM_MODE_REGISTER_RESET;
		end else begin
			o_clk_en <= next_clk_en;
			o_state <= next_state;
			o_system_mode_register_rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// ### verif/pmwc_props.sv
`timescale 1ns/1ps
`default_nettype none

module pmwc_props (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// inputs
	input wire pmwc_pkg::pmwc_osc_cfg_t i_osc_cfg,
	input wire logic i_idle_clock_keep,
	input wire logic i_system_mode_register_wr,
	input wire logic i_halt,
	input wire logic i_wake,
	input wire logic i_wdt_timeout,
	// outputs
	input wire logic [7:0] o_system_mode_register_rdata,
	input wire logic o_power_down_flag,
	input wire logic o_watchdog_timeout_flag,
	input wire logic o_wdt_clear,
	input wire pmwc_pkg::pmwc_state_t o_state,
	input wire pmwc_pkg::pmwc_clk_en_t o_clk_en,
	input wire logic o_fh16_tick,
	input wire logic o_fh64_tick
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);

	// ----------------
	// decode
	// ----------------
	wire logic s_all = o_state == pmwc_pkg::PMWC_SLEEP_ALL;
	wire logic s_sub = o_state == pmwc_pkg::PMWC_SLEEP_SUB;
	wire logic s_off = o_state == pmwc_pkg::PMWC_IDLE_OFF;
	wire logic s_on = o_state == pmwc_pkg::PMWC_IDLE_ON;
	wire logic s_slow = o_state == pmwc_pkg::PMWC_RUN_SLOW;
	wire logic go = i_halt && (s_slow || o_state == pmwc_pkg::PMWC_RUN_FAST);
	wire logic bg = i_osc_cfg.wdt_enable || i_osc_cfg.lvd_enable;
	wire logic ie = o_system_mode_register_rdata[1];

	// ----------------
	// properties
	// ----------------
	halt_flag_a: assert property (
		go && !i_wdt_timeout |=> o_power_down_flag && !o_watchdog_timeout_flag)
		else $error("halt flags wrong");
	// read data lags the register, so halts right after a write are skipped
	sleep_pick_a: assert property (
		go && !$past(i_system_mode_register_wr) && !ie |=> (bg ? s_sub : s_all))
		else $error("wrong sleep state");
	idle_pick_a: assert property (
		go && !$past(i_system_mode_register_wr) && ie |=> (i_idle_clock_keep ? s_on : s_off))
		else $error("wrong idle state");
	wdt_pulse_a: assert property (
		go |=> o_wdt_clear ##1 !o_wdt_clear)
		else $error("watchdog clear pulse wrong");
	all_off_a: assert property (
		s_all |-> !(o_clk_en.cpu || o_clk_en.wdt || o_clk_en.time_base || o_clk_en.slow_osc))
		else $error("clock left on in deep sleep");
	sub_on_a: assert property (
		s_sub |-> !o_clk_en.cpu && !o_clk_en.time_base && o_clk_en.slow_osc)
		else $error("sleep clocks wrong");
	idle_off_a: assert property (
		s_off |-> !o_clk_en.cpu && !o_clk_en.sys_fast && o_clk_en.time_base && o_clk_en.slow_osc)
		else $error("idle clocks wrong");
	no_fast_a: assert property (
		s_all && i_wake |=> o_state != pmwc_pkg::PMWC_WAKE_SUB)
		else $error("fast wake from deep sleep");
	fast_wake_a: assert property (
		(s_sub || s_off) && i_wake && o_system_mode_register_rdata[4] && o_system_mode_register_rdata[0] && i_osc_cfg.fast_is_crystal
		|=> o_state == pmwc_pkg::PMWC_WAKE_SUB)
		else $error("fast wake not taken");
	fh_stop_a: assert property (
		!o_clk_en.fast_osc |-> !o_fh16_tick && !o_fh64_tick)
		else $error("divided ticks in slow mode");
endmodule

bind pmwc_top pmwc_props u_props (
	.i_sys_clk, .i_nrst, .i_osc_cfg, .i_idle_clock_keep, .i_system_mode_register_wr, .i_halt, .i_wake,
	.i_wdt_timeout, .o_system_mode_register_rdata, .o_power_down_flag, .o_watchdog_timeout_flag,
	.o_wdt_clear, .o_state, .o_clk_en, .o_fh16_tick, .o_fh64_tick
);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("BAD %s expected %0h seen %0h", n, e, g); \
	end \
end

module tb_top;
	logic i_sys_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [2:0] tc = 3'h0;
	logic i_fast_tick = 1'b0;
	logic i_slow_tick = 1'b0;
	pmwc_pkg::pmwc_osc_cfg_t i_osc_cfg = 4'hC;
	logic i_idle_clock_keep = 1'b0;
	logic i_system_mode_register_wr = 1'b0;
	logic [7:0] i_system_mode_register_wdata = 8'h00;
	// strobes: halt, wake, clear, timeout
	logic [3:0] ev = 4'h0;
	wire logic i_halt = ev[0];
	wire logic i_wake = ev[1];
	wire logic i_wdt_clear_instr = ev[2];
	wire logic i_wdt_timeout = ev[3];
	logic [7:0] o_system_mode_register_rdata;
	logic o_power_down_flag;
	logic o_watchdog_timeout_flag;
	logic o_sys_tick;
	pmwc_pkg::pmwc_state_t o_state, tg, wk;
	pmwc_pkg::pmwc_clk_en_t o_clk_en;
	logic [4:0] r;
	int errors = 0;
	int check_count = 0;
	int cyc, lo;
	// idle_enable, idle_clock_keep, fast crystal, watchdog, detector
	localparam logic [4:0] rows [6] = '{5'h04, 5'h06, 5'h05, 5'h14, 5'h1C, 5'h02};

	pmwc_top dut (
		.i_sys_clk, .i_nrst, .i_fast_tick, .i_slow_tick, .i_osc_cfg, .i_idle_clock_keep,
		.i_system_mode_register_wr, .i_system_mode_register_wdata, .o_system_mode_register_rdata, .i_halt, .i_wake, .i_wdt_clear_instr,
		.i_wdt_timeout, .o_power_down_flag, .o_watchdog_timeout_flag, .o_wdt_clear(),
		.o_state, .o_clk_en, .o_sys_tick, .o_fh16_tick(), .o_fh64_tick()
	);

	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// fast oscillator every 2 cycles, slow every 8
	always @(posedge i_sys_clk) begin
		tc <= tc + 3'h1;
		i_fast_tick <= tc[0];
		i_slow_tick <= tc == 3'h7;
	end

	// ----------------
	// access tasks
	// ----------------
	task automatic strobe(input logic [3:0] m);
		@(posedge i_sys_clk);
		ev <= m;
		@(posedge i_sys_clk);
		ev <= 4'h0;
		#1;
	endtask

	task automatic wr_system_mode_register(input logic [7:0] d);
		@(posedge i_sys_clk);
		i_system_mode_register_wr <= 1'b1;
		i_system_mode_register_wdata <= d;
		@(posedge i_sys_clk);
		i_system_mode_register_wr <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic wait_st(input pmwc_pkg::pmwc_state_t s);
		while (o_state !== s && cyc < 3000) begin
			@(posedge i_sys_clk);
			#1;
			cyc++;
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (16) @(posedge i_sys_clk);
		`CHK("reset system_mode_register", 8'h03, o_system_mode_register_rdata)
		`CHK("reset state", pmwc_pkg::PMWC_RUN_FAST, o_state)
		i_nrst <= 1'b1;
		cyc = 0;
		while (o_system_mode_register_rdata[3] !== 1'b1 && cyc < 3000) begin
			@(posedge i_sys_clk);
			#1;
			cyc++;
		end
		`CHK("slow settle", 1'b1, cyc >= 1016 && cyc <= 1048)
		repeat (16) @(posedge i_sys_clk);
		wr_system_mode_register(8'hF0);
		`CHK("system_mode_register rw", 8'hFC, o_system_mode_register_rdata)
		`CHK("div 111 fast", pmwc_pkg::PMWC_RUN_FAST, o_state)
		$display("reset test done");
		foreach (rows[i]) begin
			r = rows[i];
			tg = r[4] ? (r[3] ? pmwc_pkg::PMWC_IDLE_ON : pmwc_pkg::PMWC_IDLE_OFF)
				: (r[1:0] != 2'h0 ? pmwc_pkg::PMWC_SLEEP_SUB : pmwc_pkg::PMWC_SLEEP_ALL);
			wk = r[2] && (tg == pmwc_pkg::PMWC_SLEEP_SUB || tg == pmwc_pkg::PMWC_IDLE_OFF)
				? pmwc_pkg::PMWC_WAKE_SUB : pmwc_pkg::PMWC_WAKE_FAST;
			lo = !r[2] ? 24 : (tg == pmwc_pkg::PMWC_IDLE_ON ? 0 : 1016);
			@(posedge i_sys_clk);
			i_osc_cfg <= {r[2], 1'b1, r[1:0]};
			i_idle_clock_keep <= r[3];
			wr_system_mode_register(8'h11 | {6'h00, r[4], 1'b0});
			strobe(4'h8);
			`CHK("timeout set", 1'b1, o_watchdog_timeout_flag)
			strobe(4'h1);
			`CHK("halt state", tg, o_state)
			`CHK("pdf", 1'b1, o_power_down_flag)
			`CHK("timeout flag", 1'b0, o_watchdog_timeout_flag)
			strobe(4'h1);
			`CHK("halt ignored", tg, o_state)
			strobe(4'h2);
			cyc = 0;
			if (tg != pmwc_pkg::PMWC_IDLE_ON) begin
				`CHK("wake state", wk, o_state)
			end
			if (wk == pmwc_pkg::PMWC_WAKE_SUB) begin
				repeat (20) @(posedge i_sys_clk);
				#1;
				cyc = 20;
				`CHK("sub run", 2'h3, {o_clk_en.cpu, o_clk_en.sys_sub})
			end
			wait_st(pmwc_pkg::PMWC_RUN_FAST);
			`CHK("wake time", 1'b1, cyc >= lo && cyc <= lo + 24)
			strobe(4'h4);
			`CHK("pdf cleared", 1'b0, o_power_down_flag)
			`CHK("fast ready", 1'b1, o_system_mode_register_rdata[2])
			$display("halt row %0d done", i);
		end
		for (int d = 0; d < 8; d++) begin
			wr_system_mode_register({d[2:0], 5'h00});
			tg = d < 2 ? pmwc_pkg::PMWC_RUN_SLOW : pmwc_pkg::PMWC_RUN_FAST;
			cyc = 0;
			wait_st(tg);
			`CHK("run state", tg, o_state)
			`CHK("fast osc", d > 1, o_clk_en.fast_osc)
			`CHK("slow ready", 1'b1, o_system_mode_register_rdata[3])
			if (d == 2) begin
				// last halt row left the fast side on the internal RC: 16 ticks
				`CHK("fast switch time", 1'b1, cyc >= 24 && cyc <= 48)
			end
			if (d == 7) begin
				lo = 0;
				repeat (64) begin
					@(posedge i_sys_clk);
					#1;
					lo += o_sys_tick;
				end
				`CHK("sys tick rate", 1'b1, lo >= 15 && lo <= 17)
			end
			if (d == 1) begin
				strobe(4'h1);
				strobe(4'h2);
				`CHK("slow wake", pmwc_pkg::PMWC_WAKE_SLOW, o_state)
				wait_st(tg);
				`CHK("back slow", tg, o_state)
			end
		end
		$display("mode switch test done");
		give_verdict();
	end

	initial begin
		repeat (30000) @(posedge i_sys_clk);
		errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
